// ---- hdl/record_clock_pkg.sv ----
// Constants, register map and bus carriers for the record clock generator
package record_clock_pkg;

    // ------------------------------------------------------------------
    // Bus geometry
    // ------------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam int IDX_W = 10;
    localparam int WORD_LSB = 2;
    localparam int DATA_W = 32;
    localparam int REG_W = 8;

    typedef logic [IDX_W-1:0] regIdx_t;
    typedef logic [REG_W-1:0] regByte_t;

    // ------------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------------
    localparam regIdx_t IDX_RESERVED_0F = 10'h00f;
    localparam regIdx_t IDX_RESERVED_10 = 10'h010;
    localparam regIdx_t IDX_RESERVED_11 = 10'h011;
    localparam regIdx_t IDX_REC_CLK_DIV = 10'h012;
    localparam regIdx_t IDX_REC_MOD_DIV = 10'h013;
    localparam regIdx_t IDX_REC_OSR = 10'h014;
    localparam regIdx_t IDX_RESERVED_15 = 10'h015;
    localparam regIdx_t IDX_RESERVED_16 = 10'h016;
    localparam regIdx_t IDX_RESERVED_17 = 10'h017;
    localparam regIdx_t IDX_RESERVED_18 = 10'h018;
    localparam regIdx_t IDX_CLK_OUT_SEL = 10'h019;
    localparam regIdx_t IDX_CLK_OUT_DIV = 10'h01a;
    localparam regIdx_t IDX_CLOCK_STATUS = 10'h040;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam regByte_t RST_RESERVED_0F = 8'h02;
    localparam regByte_t RST_RESERVED_10 = 8'h00;
    localparam regByte_t RST_RESERVED_11 = 8'h08;
    localparam regByte_t RST_REC_CLK_DIV = 8'h01;
    localparam regByte_t RST_REC_MOD_DIV = 8'h01;
    localparam regByte_t RST_REC_OSR = 8'h80;
    localparam regByte_t RST_RESERVED_15 = 8'h01;
    localparam regByte_t RST_RESERVED_16 = 8'h00;
    localparam regByte_t RST_RESERVED_17 = 8'h04;
    localparam regByte_t RST_RESERVED_18 = 8'h00;
    localparam regByte_t RST_CLK_OUT_SEL = 8'h00;
    localparam regByte_t RST_CLK_OUT_DIV = 8'h01;

    // ------------------------------------------------------------------
    // Field positions and codes
    // ------------------------------------------------------------------
    localparam int POWER_BIT = 7;
    localparam int DIV_MSB = 6;
    localparam int SEL_MSB = 2;
    localparam logic [6:0] DIV_CODE_MAX_RATIO = 7'h00;
    localparam logic [7:0] DIV_RATIO_MAX = 8'h80;
    localparam logic [7:0] OSR_CODE_256 = 8'h00;
    localparam logic [7:0] OSR_CODE_32 = 8'h20;
    localparam logic [7:0] OSR_CODE_64 = 8'h40;
    localparam logic [7:0] OSR_CODE_128 = 8'h80;
    localparam logic [8:0] OSR_RATIO_256 = 9'h100;
    localparam logic [8:0] OSR_RATIO_32 = 9'h020;
    localparam logic [8:0] OSR_RATIO_64 = 9'h040;
    localparam logic [8:0] OSR_RATIO_128 = 9'h080;
    localparam logic [8:0] OSR_RATIO_NONE = 9'h000;

    // Clock-output source select codes, also bit positions in the source vector
    typedef enum logic [2:0] {
        SRC_MASTER_CLK = 3'h0,
        SRC_BIT_CLK = 3'h1,
        SRC_DATA_IN = 3'h2,
        SRC_PLL_CLK = 3'h3,
        SRC_PLAYBACK_CLK = 3'h4,
        SRC_PLAYBACK_MOD_CLK = 3'h5,
        SRC_RECORD_CLK = 3'h6,
        SRC_RECORD_MOD_CLK = 3'h7
    } clkOutSrc_e;

    // Status register bit positions
    localparam int ST_REC_CLK = 0;
    localparam int ST_REC_MOD_CLK = 1;
    localparam int ST_REC_SAMPLE_CLK = 2;
    localparam int ST_CLK_OUT = 3;
    localparam int ST_OSR_RESERVED = 4;
    localparam int ST_REC_DIV_ON = 5;
    localparam int ST_REC_MOD_DIV_ON = 6;
    localparam int ST_CLK_OUT_DIV_ON = 7;

    // AXI4-Lite responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    // ------------------------------------------------------------------
    // AXI4-Lite carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic awvalid;
        logic [ADDR_W-1:0] awaddr;
        logic wvalid;
        logic [DATA_W-1:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [ADDR_W-1:0] araddr;
        logic rready;
    } axiReq_s;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [DATA_W-1:0] rdata;
        logic [1:0] rresp;
    } axiRsp_s;

endpackage

// ---- hdl/record_clock_gen.sv ----
// Record clock dividers, oversampling divider and clock-output path with AXI4-Lite registers
`timescale 1ns/10ps

// ----------------------------------------------------------------------
// Overview of operation
// ----------------------------------------------------------------------
// Overview of operation
// - Record divider off: record clock follows playback
// - Record divider code 0 means 128
// - Modulator divider off: follows playback modulator clock
// - Modulator divider code 0 means 128
// - Oversampling code zero gives ratio 256
// - Code 0x20 gives ratio 32
// - Code 0x40 gives ratio 64
// - Code 0x80 gives ratio 128
// - Output sources 0-3: master, bit, data, PLL
// - Output sources 4-7: playback and record clocks
// - Output divider power bit gates it
// - Output divider code 0 means 128

// ----------------------------------------------------------------------
// Edge-counting divider on sampled clock levels
// ----------------------------------------------------------------------
module record_clock_divider
#(
    parameter int RW = 8
)
(
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic enable,
    input wire logic [RW-1:0] ratio,
    input wire logic srcLvl,
    input wire logic srcRise,
    output logic divLvl,
    output logic divNext
);
    logic [RW-1:0] cnt_q;
    logic [RW-1:0] cnt_d;
    logic lvl_q;
    logic lvl_d;

    // Width below two cannot hold a ratio of two or more
    if (RW < 2)
    begin : badWidth
        $error("record_clock_divider: RW must be at least 2");
    end

    // Next count and level; high for the first half of each period
    always_comb
    begin
        cnt_d = cnt_q;
        lvl_d = lvl_q;
        if (!enable)
        begin
            cnt_d = '0;
            lvl_d = 1'b0;
        end
        else if (ratio == RW'(1))
        begin
            cnt_d = '0;
            lvl_d = srcLvl;
        end
        else if (srcRise)
        begin
            // Wrap with >= so a ratio lowered mid-period recovers at once
            cnt_d = (cnt_q >= ratio - RW'(1)) ? '0 : cnt_q + RW'(1);
            lvl_d = (cnt_d < (ratio >> 1));
        end
    end

    // Count and level registers
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            cnt_q <= '0;
            lvl_q <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_d;
            lvl_q <= lvl_d;
        end
    end

    assign divLvl = lvl_q;
    assign divNext = lvl_d;
endmodule // record_clock_divider

// ----------------------------------------------------------------------
// Top level
// ----------------------------------------------------------------------
module record_clock_gen
    import record_clock_pkg::*;
(
    input wire logic sys_clk,
    input wire logic nrst,
    input wire axiReq_s axiReq,
    output axiRsp_s axiRsp,
    input wire logic masterClk,
    input wire logic bitClk,
    input wire logic dataIn,
    input wire logic pllClk,
    input wire logic codecClkIn,
    input wire logic playbackClk,
    input wire logic playbackModClk,
    output logic recordClock,
    output logic recordModulatorClock,
    output logic recordSampleClock,
    output logic clockOutput
);
    localparam int NSRC = 7;
    localparam int PIN_MCLK = 0;
    localparam int PIN_BCLK = 1;
    localparam int PIN_DIN = 2;
    localparam int PIN_PLL = 3;
    localparam int PIN_PB = 4;
    localparam int PIN_PBMOD = 5;
    localparam int PIN_CODEC = 6;

    // ------------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------------
    // Seven-bit divider code to ratio; all-zero code selects 128
    function automatic logic [7:0] divRatio(input logic [6:0] code);
        divRatio = (code == DIV_CODE_MAX_RATIO) ? DIV_RATIO_MAX : {1'b0, code};
    endfunction

    // Oversampling code to ratio; reserved codes yield zero
    function automatic logic [8:0] osrRatio(input logic [7:0] code);
        unique case (code)
            OSR_CODE_256: osrRatio = OSR_RATIO_256;
            OSR_CODE_32: osrRatio = OSR_RATIO_32;
            OSR_CODE_64: osrRatio = OSR_RATIO_64;
            OSR_CODE_128: osrRatio = OSR_RATIO_128;
            default: osrRatio = OSR_RATIO_NONE;
        endcase
    endfunction

    // Index lies in this bank's map
    function automatic logic isMapped(input regIdx_t idx);
        isMapped = (idx >= IDX_RESERVED_0F && idx <= IDX_CLK_OUT_DIV)
                   || idx == IDX_CLOCK_STATUS;
    endfunction

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    regByte_t recClkDiv_q;
    regByte_t recModDiv_q;
    regByte_t recOsr_q;
    regByte_t reserved10_q;
    logic [SEL_MSB:0] clkOutSel_q;
    regByte_t clkOutDiv_q;
    logic [NSRC-1:0] sync1_q;
    logic [NSRC-1:0] sync2_q;
    logic [NSRC-1:0] sync3_q;
    logic [NSRC-1:0] pinLvl_q;
    logic [NSRC-1:0] pinLvl_d;
    logic [NSRC-1:0] pinRise;
    logic recDivLvl;
    logic recDivNext;
    logic recClk_q;
    logic recClk_d;
    logic recRise;
    logic modDivLvl;
    logic modDivNext;
    logic recMod_q;
    logic recMod_d;
    logic recModRise;
    logic [8:0] osrRatioNow;
    logic osrReserved;
    logic sampleLvl;
    logic sampleNext;
    logic [7:0] outSrcLvl;
    logic [7:0] outSrcRise;
    logic outDivLvl;
    logic outDivNext;
    logic awHeld_q;
    logic [IDX_W-1:0] awIdx_q;
    logic wHeld_q;
    logic [DATA_W-1:0] wData_q;
    logic wLane0_q;
    logic bValid_q;
    logic [1:0] bResp_q;
    logic rValid_q;
    logic [DATA_W-1:0] rData_q;
    logic [1:0] rResp_q;
    logic doWrite;
    logic wrLane;
    regIdx_t arIdx;
    regByte_t rdByte;
    regByte_t statusByte;

    // ------------------------------------------------------------------
    // Pin synchronisers: three stages, level moves once stages 2 and 3 agree
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            sync1_q <= '0;
            sync2_q <= '0;
            sync3_q <= '0;
            pinLvl_q <= '0;
        end
        else
        begin
            sync1_q <= {codecClkIn, playbackModClk, playbackClk, pllClk,
                        dataIn, bitClk, masterClk};
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            pinLvl_q <= pinLvl_d;
        end
    end

    // Agreement filter and rising-edge detect
    assign pinLvl_d = (sync2_q & sync3_q) | (pinLvl_q & (sync2_q | sync3_q));
    assign pinRise = pinLvl_d & ~pinLvl_q;

    // ------------------------------------------------------------------
    // Record clock divider
    // ------------------------------------------------------------------
    record_clock_divider #(.RW(8)) recDiv (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .enable(recClkDiv_q[POWER_BIT]),
        .ratio(divRatio(recClkDiv_q[DIV_MSB:0])),
        .srcLvl(pinLvl_d[PIN_CODEC]),
        .srcRise(pinRise[PIN_CODEC]),
        .divLvl(recDivLvl),
        .divNext(recDivNext)
    );

    // Powered-down divider hands over the playback clock
    assign recClk_d = recClkDiv_q[POWER_BIT] ? recDivNext : pinLvl_d[PIN_PB];
    assign recRise = recClk_d & ~recClk_q;

    // ------------------------------------------------------------------
    // Record modulator divider, fed by the record clock
    // ------------------------------------------------------------------
    record_clock_divider #(.RW(8)) modDiv (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .enable(recModDiv_q[POWER_BIT]),
        .ratio(divRatio(recModDiv_q[DIV_MSB:0])),
        .srcLvl(recClk_d),
        .srcRise(recRise),
        .divLvl(modDivLvl),
        .divNext(modDivNext)
    );

    // Powered-down divider hands over the playback modulator clock
    assign recMod_d = recModDiv_q[POWER_BIT] ? modDivNext : pinLvl_d[PIN_PBMOD];
    assign recModRise = recMod_d & ~recMod_q;

    // Clock level registers
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            recClk_q <= 1'b0;
            recMod_q <= 1'b0;
        end
        else
        begin
            recClk_q <= recClk_d;
            recMod_q <= recMod_d;
        end
    end

    // ------------------------------------------------------------------
    // Oversampling divider down to the record sample rate
    // ------------------------------------------------------------------
    // A reserved code stops the sample clock rather than guess a ratio
    assign osrRatioNow = osrRatio(recOsr_q);
    assign osrReserved = (osrRatioNow == OSR_RATIO_NONE);

    record_clock_divider #(.RW(9)) osrDiv (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .enable(!osrReserved),
        .ratio(osrRatioNow),
        .srcLvl(recMod_d),
        .srcRise(recModRise),
        .divLvl(sampleLvl),
        .divNext(sampleNext)
    );

    // ------------------------------------------------------------------
    // Clock-output source multiplexer and divider
    // ------------------------------------------------------------------
    // Vector ordered by select code
    assign outSrcLvl = {recMod_d, recClk_d, pinLvl_d[PIN_PBMOD], pinLvl_d[PIN_PB],
                        pinLvl_d[PIN_PLL], pinLvl_d[PIN_DIN], pinLvl_d[PIN_BCLK],
                        pinLvl_d[PIN_MCLK]};
    assign outSrcRise = {recModRise, recRise, pinRise[PIN_PBMOD], pinRise[PIN_PB],
                         pinRise[PIN_PLL], pinRise[PIN_DIN], pinRise[PIN_BCLK],
                         pinRise[PIN_MCLK]};

    record_clock_divider #(.RW(8)) outDiv (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .enable(clkOutDiv_q[POWER_BIT]),
        .ratio(divRatio(clkOutDiv_q[DIV_MSB:0])),
        .srcLvl(outSrcLvl[clkOutSel_q]),
        .srcRise(outSrcRise[clkOutSel_q]),
        .divLvl(outDivLvl),
        .divNext(outDivNext)
    );

    assign recordClock = recClk_q;
    assign recordModulatorClock = recMod_q;
    assign recordSampleClock = sampleLvl;
    assign clockOutput = outDivLvl;

    // ------------------------------------------------------------------
    // AXI4-Lite write channels
    // ------------------------------------------------------------------
    // Address and data are parked independently; the write fires once both are in
    assign doWrite = awHeld_q & wHeld_q & ~bValid_q;
    assign wrLane = doWrite & wLane0_q;

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            awHeld_q <= 1'b0;
            awIdx_q <= '0;
        end
        else if (axiReq.awvalid && !awHeld_q)
        begin
            awHeld_q <= 1'b1;
            awIdx_q <= axiReq.awaddr[ADDR_W-1:WORD_LSB];
        end
        else if (doWrite)
        begin
            awHeld_q <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            wHeld_q <= 1'b0;
            wData_q <= '0;
            wLane0_q <= 1'b0;
        end
        else if (axiReq.wvalid && !wHeld_q)
        begin
            wHeld_q <= 1'b1;
            wData_q <= axiReq.wdata;
            wLane0_q <= axiReq.wstrb[0];
        end
        else if (doWrite)
        begin
            wHeld_q <= 1'b0;
        end
    end

    // Write response
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            bValid_q <= 1'b0;
            bResp_q <= RESP_OKAY;
        end
        else if (doWrite)
        begin
            bValid_q <= 1'b1;
            bResp_q <= isMapped(awIdx_q) ? RESP_OKAY : RESP_DECERR;
        end
        else if (axiReq.bready)
        begin
            bValid_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Control registers; read-only reserved bytes keep their defaults
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            recClkDiv_q <= RST_REC_CLK_DIV;
            recModDiv_q <= RST_REC_MOD_DIV;
            recOsr_q <= RST_REC_OSR;
        end
        else if (wrLane)
        begin
            if (awIdx_q == IDX_REC_CLK_DIV)
                recClkDiv_q <= wData_q[REG_W-1:0];
            if (awIdx_q == IDX_REC_MOD_DIV)
                recModDiv_q <= wData_q[REG_W-1:0];
            if (awIdx_q == IDX_REC_OSR)
                recOsr_q <= wData_q[REG_W-1:0];
        end
    end

    // Clock-output registers and writable reserved byte 0x10; select keeps only its three live bits
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            clkOutSel_q <= RST_CLK_OUT_SEL[SEL_MSB:0];
            clkOutDiv_q <= RST_CLK_OUT_DIV;
            reserved10_q <= RST_RESERVED_10;
        end
        else if (wrLane)
        begin
            if (awIdx_q == IDX_CLK_OUT_SEL)
                clkOutSel_q <= wData_q[SEL_MSB:0];
            if (awIdx_q == IDX_CLK_OUT_DIV)
                clkOutDiv_q <= wData_q[REG_W-1:0];
            if (awIdx_q == IDX_RESERVED_10)
                reserved10_q <= wData_q[REG_W-1:0];
        end
    end

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    assign arIdx = axiReq.araddr[ADDR_W-1:WORD_LSB];

    // Live clock levels and ratio/power flags for software polling; levels sampled, so slow clocks only
    always_comb
    begin
        statusByte = '0;
        statusByte[ST_REC_CLK] = recClk_q;
        statusByte[ST_REC_MOD_CLK] = recMod_q;
        statusByte[ST_REC_SAMPLE_CLK] = sampleLvl;
        statusByte[ST_CLK_OUT] = outDivLvl;
        statusByte[ST_OSR_RESERVED] = osrReserved;
        statusByte[ST_REC_DIV_ON] = recClkDiv_q[POWER_BIT];
        statusByte[ST_REC_MOD_DIV_ON] = recModDiv_q[POWER_BIT];
        statusByte[ST_CLK_OUT_DIV_ON] = clkOutDiv_q[POWER_BIT];
    end

    // Register read multiplexer
    always_comb
    begin
        rdByte = '0;
        unique case (arIdx)
            IDX_RESERVED_0F: rdByte = RST_RESERVED_0F;
            IDX_RESERVED_10: rdByte = reserved10_q;
            IDX_RESERVED_11: rdByte = RST_RESERVED_11;
            IDX_REC_CLK_DIV: rdByte = recClkDiv_q;
            IDX_REC_MOD_DIV: rdByte = recModDiv_q;
            IDX_REC_OSR: rdByte = recOsr_q;
            IDX_RESERVED_15: rdByte = RST_RESERVED_15;
            IDX_RESERVED_16: rdByte = RST_RESERVED_16;
            IDX_RESERVED_17: rdByte = RST_RESERVED_17;
            IDX_RESERVED_18: rdByte = RST_RESERVED_18;
            IDX_CLK_OUT_SEL: rdByte = {{(REG_W-SEL_MSB-1){1'b0}}, clkOutSel_q};
            IDX_CLK_OUT_DIV: rdByte = clkOutDiv_q;
            IDX_CLOCK_STATUS: rdByte = statusByte;
            default: rdByte = '0;
        endcase
    end

    // Read data channel
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rValid_q <= 1'b0;
            rData_q <= '0;
            rResp_q <= RESP_OKAY;
        end
        else if (axiReq.arvalid && !rValid_q)
        begin
            rValid_q <= 1'b1;
            rData_q <= {{(DATA_W-REG_W){1'b0}}, rdByte};
            rResp_q <= isMapped(arIdx) ? RESP_OKAY : RESP_DECERR;
        end
        else if (axiReq.rready)
        begin
            rValid_q <= 1'b0;
        end
    end

    // Handshake outputs
    assign axiRsp.awready = ~awHeld_q;
    assign axiRsp.wready = ~wHeld_q;
    assign axiRsp.bvalid = bValid_q;
    assign axiRsp.bresp = bResp_q;
    assign axiRsp.arready = ~rValid_q;
    assign axiRsp.rvalid = rValid_q;
    assign axiRsp.rdata = rData_q;
    assign axiRsp.rresp = rResp_q;
endmodule // record_clock_gen

// ---- testbench/record_clock_assertions.sv ----
// Bus handshake checker for the record clock generator
`timescale 1ns/10ps
module record_clock_assertions
    import record_clock_pkg::*;
(
    input wire logic sys_clk,
    input wire logic nrst,
    input wire axiReq_s axiReq,
    input wire axiRsp_s axiRsp
);
    // ------------------------------------------------------------------
    // Handshake timing
    // ------------------------------------------------------------------
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);
    // Channel transfers taken at this edge
    sequence awTaken;
        axiReq.awvalid && axiRsp.awready;
    endsequence
    sequence wTaken;
        axiReq.wvalid && axiRsp.wready;
    endsequence
    a_write_answer: assert property (awTaken and wTaken |-> ##[1:2] axiRsp.bvalid)
        else $error("write not answered");
    a_read_answer: assert property (axiReq.arvalid && axiRsp.arready |=> axiRsp.rvalid)
        else $error("read not answered");
    a_bvalid_drop: assert property (axiRsp.bvalid && axiReq.bready |=> !axiRsp.bvalid)
        else $error("write answer not released");
    a_rvalid_drop: assert property (axiRsp.rvalid && axiReq.rready |=> !axiRsp.rvalid)
        else $error("read answer not released");
    a_arready_busy: assert property (axiRsp.rvalid |-> !axiRsp.arready)
        else $error("read taken while answer pending");
    a_aw_parked: assert property (awTaken |=> !axiRsp.awready)
        else $error("address taken twice");
    a_w_parked: assert property (wTaken |=> !axiRsp.wready)
        else $error("data taken twice");
    a_decerr_zero: assert property (axiRsp.rvalid && axiRsp.rresp == RESP_DECERR
        |-> axiRsp.rdata == 32'h0)
        else $error("refused read returned data");
endmodule // record_clock_assertions

bind record_clock_gen record_clock_assertions chk (.sys_clk(sys_clk), .nrst(nrst),
    .axiReq(axiReq), .axiRsp(axiRsp));

// ---- testbench/record_clock_gen_bench.sv ----
// Register and clock-period tests for the record clock generator
`timescale 1ns/10ps
`define CHK(n, e, v) begin compares++; if ((v) !== (e)) begin failures++; \
    $display("mismatch %s expected %0h seen %0h", n, e, v); end end
module record_clock_gen_bench import record_clock_pkg::*;;
    typedef struct {regByte_t i; regByte_t v; int k; int e;} step_s;
    logic sys_clk, nrst;
    axiReq_s q;
    axiRsp_s r;
    logic [6:0] src;
    logic [3:0] mon;
    regByte_t d;
    logic [1:0] s;
    int p, failures, compares, cyc;
    int cnt[7];
    int half[7] = '{2, 3, 6, 7, 4, 5, 9};
    regByte_t rVal[12] = '{8'h02, 8'h00, 8'h08, 8'h01, 8'h01, 8'h80, 8'h01, 8'h00, 8'h04,
        8'h00, 8'h00, 8'h01};
    // Register write, watched output, expected period in cycles
    step_s st[25] = '{'{8'h12, 8'h01, 0, 10}, '{8'h13, 8'h01, 1, 18},
        '{8'h12, 8'h83, 0, 24}, '{8'h13, 8'h82, 1, 48}, '{8'h12, 8'h80, 0, 1024},
        '{8'h12, 8'h81, 0, 8}, '{8'h13, 8'h80, 1, 1024}, '{8'h13, 8'h81, 2, 1024},
        '{8'h14, 8'h20, 2, 256}, '{8'h14, 8'h40, 2, 512}, '{8'h14, 8'h00, 2, 2048},
        '{8'h1a, 8'h81, 3, 8}, '{8'h12, 8'h83, 0, 24}, '{8'h13, 8'h82, 1, 48},
        '{8'h19, 8'h00, 3, 4}, '{8'h19, 8'h01, 3, 6}, '{8'h19, 8'h02, 3, 12},
        '{8'h19, 8'h03, 3, 14}, '{8'h19, 8'h04, 3, 10}, '{8'h19, 8'h05, 3, 18},
        '{8'h19, 8'h06, 3, 24}, '{8'h19, 8'h07, 3, 48}, '{8'h19, 8'h00, 3, 4},
        '{8'h1a, 8'h80, 3, 512}, '{8'h1a, 8'h00, 3, 0}};
    record_clock_gen dut (.sys_clk(sys_clk), .nrst(nrst), .axiReq(q), .axiRsp(r),
        .masterClk(src[0]), .bitClk(src[1]), .dataIn(src[2]), .pllClk(src[3]),
        .codecClkIn(src[4]), .playbackClk(src[5]), .playbackModClk(src[6]),
        .recordClock(mon[0]), .recordModulatorClock(mon[1]), .recordSampleClock(mon[2]),
        .clockOutput(mon[3]));
    // ------------------------------------------------------------------
    // Clock, sources and timeout
    // ------------------------------------------------------------------
    always #25 sys_clk = ~sys_clk;
    // Distinct slow periods so each selected source is recognisable
    always @(posedge sys_clk)
    begin
        for (int j = 0; j < 7; j++)
            if (cnt[j] == half[j] - 1)
            begin
                cnt[j] <= 0;
                src[j] <= ~src[j];
            end
            else
                cnt[j] <= cnt[j] + 1;
        cyc++;
        if (cyc == 60000)
        begin
            failures++;
            report_and_stop;
        end
    end
    // ------------------------------------------------------------------
    // Bus tasks; ready sampled at the falling edge, where it is settled
    // ------------------------------------------------------------------
    task automatic wr(input regIdx_t i, input regByte_t v);
        logic a, w;
        @(posedge sys_clk);
        a = 1'b1;
        w = 1'b1;
        q.awaddr <= {i, 2'b00};
        q.wdata <= {24'h0, v};
        q.wstrb <= 4'hf;
        q.awvalid <= 1'b1;
        q.wvalid <= 1'b1;
        q.bready <= 1'b1;
        while (a || w)
        begin
            @(negedge sys_clk);
            a = a && (r.awready !== 1'b1);
            w = w && (r.wready !== 1'b1);
            @(posedge sys_clk);
            q.awvalid <= a;
            q.wvalid <= w;
        end
        do @(negedge sys_clk); while (r.bvalid !== 1'b1);
        s = r.bresp;
        @(posedge sys_clk);
        q.bready <= 1'b0;
    endtask
    task automatic rd(input regIdx_t i, output regByte_t v, output logic [1:0] e);
        @(posedge sys_clk);
        q.araddr <= {i, 2'b00};
        q.arvalid <= 1'b1;
        q.rready <= 1'b1;
        do @(negedge sys_clk); while (r.arready !== 1'b1);
        @(posedge sys_clk);
        q.arvalid <= 1'b0;
        do @(negedge sys_clk); while (r.rvalid !== 1'b1);
        v = r.rdata[7:0];
        e = r.rresp;
        @(posedge sys_clk);
        q.rready <= 1'b0;
    endtask
    // Second full period after a change; the first may be cut short
    task automatic per(input int k, output int n);
        int t[3];
        int c;
        logic o;
        c = 0;
        o = 1'b1;
        n = 0;
        for (int j = 0; j < 7000 && c < 3; j++)
        begin
            @(negedge sys_clk);
            if (mon[k] === 1'b1 && o === 1'b0)
            begin
                t[c] = j;
                c++;
            end
            o = mon[k];
        end
        if (c == 3)
            n = t[2] - t[1];
        @(posedge sys_clk);
    endtask
    task report_and_stop;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        sys_clk = 1'b0;
        nrst = 1'b0;
        q = '0;
        src = '0;
        failures = 0;
        compares = 0;
        cyc = 0;
        foreach (cnt[j]) cnt[j] = 0;
        repeat (2) @(posedge sys_clk);
        nrst <= 1'b1;
        @(posedge sys_clk);
        for (int j = 0; j < 12; j++)
        begin
            rd(regIdx_t'(j + 15), d, s);
            `CHK("reset value", rVal[j], d)
            `CHK("read resp", RESP_OKAY, s)
        end
        wr(10'h00f, 8'hff);
        `CHK("write resp", RESP_OKAY, s)
        rd(10'h00f, d, s);
        `CHK("read-only reserved", 8'h02, d)
        wr(10'h019, 8'hff);
        rd(10'h019, d, s);
        `CHK("source select", 8'h07, d)
        rd(10'h3ff, d, s);
        `CHK("unmapped resp", RESP_DECERR, s)
        foreach (st[j])
        begin
            wr({2'b00, st[j].i}, st[j].v);
            per(st[j].k, p);
            `CHK("period", st[j].e, p)
        end
        wr(10'h014, 8'h01);
        rd(10'h040, d, s);
        `CHK("reserved ratio flag", 1'b1, d[ST_OSR_RESERVED])
        report_and_stop;
    end
endmodule // record_clock_gen_bench
